// >>> rtl/chip_reset_sequencer.sv
// Contract
// R01: Both pins low gives full power-on reset
// R02: Test reset high, global low: warm reset
// R03: Watchdog or emulator command gives max reset
// R04: System reset spares memory, emulation, clocks, power
// R05: Software resets one chosen module alone
// R06: Board holds global reset low long enough
// R07: Config pins captured on global reset rise
// R08: After power-on reset, defaults then boot
// R09: After warm/max reset, emulation kept, boot starts
// R10: Global reset active low; test reset resets debug port; code resets emulation only while global reset is also low
// R11: System reset spares DDR, PLL, power, emulation
// R12: Emulator may block watchdog max reset
// R13: Resets assert async, release through two flops
module chip_reset_sequencer (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic global_reset_n_i,
    input wire logic test_port_reset_n_i,
    input wire logic watchdog_expiry_i,
    input wire logic emu_max_req_i,
    input wire logic emu_sys_req_i,
    input wire logic emu_block_wdt_i,
    input wire logic [rst_seq_pkg::CFG_W-1:0] cfg_pins_i,
    input wire logic sw_mod_rst_i,
    input wire logic [rst_seq_pkg::MOD_IDX_W-1:0] sw_mod_sel_i,
    output logic core_rst_n_o,
    output logic mem_rst_n_o,
    output logic emu_rst_n_o,
    output logic infra_rst_n_o,
    output logic [rst_seq_pkg::MOD_W-1:0] mod_rst_n_o,
    output logic [rst_seq_pkg::CFG_W-1:0] cfg_latched_o,
    output logic boot_start_o,
    output rst_seq_pkg::rst_kind_t last_kind_o
);
    import rst_seq_pkg::*;

    logic rst_n;
    logic gr_n_q;
    logic soft_max_q;
    logic soft_sys_q;
    logic [3:0] hold_q;
    logic [MOD_W-1:0] mod_req_q;
    logic core_req_n, mem_req_n, emu_req_n, infra_req_n;
    logic core_s_n, mem_s_n, emu_s_n, infra_s_n;
    logic [MOD_W-1:0] mod_s_n;
    logic pin_active, wdt_ok, soft_go, gr_rise;
    seq_state_t state_q;

    function automatic logic [MOD_W-1:0] onehot(input logic [MOD_IDX_W-1:0] idx);
        onehot = MOD_W'(1) << idx;
    endfunction : onehot

    rst_sync u_por_sync (
        .clk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .rst_n_o(rst_n)
    );

    // ============================================================
    // Reset decode
    assign pin_active = !global_reset_n_i; // R10
    assign wdt_ok = watchdog_expiry_i && !emu_block_wdt_i; // R12
    assign soft_go = (wdt_ok || emu_max_req_i) && state_q == ST_IDLE && !pin_active; // R03
    assign gr_rise = global_reset_n_i && !gr_n_q; // R07

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            // Idle level, so no false rise after reset
            gr_n_q <= 1'b1;
        end else begin
            gr_n_q <= global_reset_n_i;
        end
    end

    // ============================================================
    // Software-triggered max and system holds
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            hold_q <= 4'h0;
            soft_max_q <= 1'b0;
            soft_sys_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (soft_go) begin
                        state_q <= ST_HOLD;
                        soft_max_q <= 1'b1; // R03
                        hold_q <= SOFT_HOLD_CNT;
                    end else if (emu_sys_req_i && !pin_active) begin
                        state_q <= ST_HOLD;
                        soft_sys_q <= 1'b1; // R04
                        hold_q <= SOFT_HOLD_CNT;
                    end
                end
                ST_HOLD: begin
                    if (hold_q == 4'h1) begin
                        state_q <= ST_BOOT;
                        soft_max_q <= 1'b0;
                        soft_sys_q <= 1'b0;
                    end
                    hold_q <= hold_q - 4'h1;
                end
                ST_BOOT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Reset requests per domain
    assign core_req_n = !(pin_active || soft_max_q || soft_sys_q); // R01 R02 R04
    assign mem_req_n = !(pin_active || soft_max_q); // R04
    assign infra_req_n = !(pin_active || soft_max_q); // R11
    assign emu_req_n = !(pin_active && !test_port_reset_n_i); // R01 R02 R09 R10

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mod_req_q <= '0;
        end else begin
            mod_req_q <= sw_mod_rst_i ? onehot(sw_mod_sel_i) : '0; // R05
        end
    end

    // ============================================================
    // Per-domain synchronisers
    rst_sync u_core (.clk_i(mclk_i), .arst_n_i(rst_n & core_req_n), .rst_n_o(core_s_n)); // R13
    rst_sync u_mem (.clk_i(mclk_i), .arst_n_i(rst_n & mem_req_n), .rst_n_o(mem_s_n)); // R13
    rst_sync u_emu (.clk_i(mclk_i), .arst_n_i(rst_n & emu_req_n), .rst_n_o(emu_s_n)); // R13
    rst_sync u_inf (.clk_i(mclk_i), .arst_n_i(rst_n & infra_req_n), .rst_n_o(infra_s_n)); // R13

    for (genvar g = 0; g < MOD_W; g++) begin : g_mod
        rst_sync u_m (.clk_i(mclk_i), .arst_n_i(rst_n & core_s_n & !mod_req_q[g]), .rst_n_o(mod_s_n[g])); // R05
    end

    assign core_rst_n_o = core_s_n;
    assign mem_rst_n_o = mem_s_n;
    assign emu_rst_n_o = emu_s_n;
    assign infra_rst_n_o = infra_s_n;
    assign mod_rst_n_o = mod_s_n;

    // ============================================================
    // Config capture, kind and boot
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_latched_o <= CFG_RST_VAL;
        end else if (gr_rise || (soft_go)) begin
            cfg_latched_o <= cfg_pins_i; // R07
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            last_kind_o <= RK_POR;
        end else if (pin_active) begin
            last_kind_o <= test_port_reset_n_i ? RK_WARM : RK_POR; // R01 R02
        end else if (soft_go) begin
            last_kind_o <= RK_MAX;
        end else if (state_q == ST_IDLE && emu_sys_req_i) begin
            last_kind_o <= RK_SYS;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot_start_o <= 1'b0;
        end else begin
            boot_start_o <= 1'b0;
            if (gr_rise || (state_q == ST_BOOT && last_kind_o == RK_MAX)) begin
                boot_start_o <= 1'b1; // R08 R09
            end
        end
    end

    // ============================================================
    // Checks
    a_por_all_rst: assert property (@(posedge mclk_i) disable iff (!rst_n) // R01
        !global_reset_n_i && !test_port_reset_n_i |=> !emu_rst_n_o && !mem_rst_n_o && !core_rst_n_o)
        else $error("por did not reset all");
    a_warm_keep_emu: assert property (@(posedge mclk_i) disable iff (!rst_n) // R02
        !global_reset_n_i && test_port_reset_n_i && $past(emu_rst_n_o) |-> emu_rst_n_o)
        else $error("warm reset hit emulation");
    a_max_hold: assert property (@(posedge mclk_i) disable iff (!rst_n) // R03
        soft_go |=> !core_rst_n_o && !mem_rst_n_o)
        else $error("max reset missing");
    a_max_kind: assert property (@(posedge mclk_i) disable iff (!rst_n) // R03
        soft_go |=> last_kind_o == RK_MAX)
        else $error("max reset kind wrong");
    a_hold_len: assert property (@(posedge mclk_i) disable iff (!rst_n) // R03
        $rose(soft_max_q) |-> soft_max_q[*8] ##1 !soft_max_q)
        else $error("max hold length wrong");
    a_sys_spare_mem: assert property (@(posedge mclk_i) disable iff (!rst_n) // R04 R11
        soft_sys_q && global_reset_n_i && $past(mem_rst_n_o && infra_rst_n_o) |-> mem_rst_n_o && infra_rst_n_o)
        else $error("system reset hit memory");
    a_mod_one: assert property (@(posedge mclk_i) disable iff (!rst_n) // R05
        sw_mod_rst_i && core_rst_n_o |=> !mod_rst_n_o[$past(sw_mod_sel_i)])
        else $error("module reset select wrong");
    a_cfg_cap: assert property (@(posedge mclk_i) disable iff (!rst_n) // R07
        gr_rise |=> cfg_latched_o == $past(cfg_pins_i))
        else $error("config not captured");
    a_boot_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n) // R08
        gr_rise |=> boot_start_o ##1 !boot_start_o)
        else $error("boot pulse wrong");
    a_max_keep_emu: assert property (@(posedge mclk_i) disable iff (!rst_n) // R09
        soft_max_q && global_reset_n_i && $past(emu_rst_n_o) |-> emu_rst_n_o)
        else $error("max reset hit emulation");
    a_boot_max: assert property (@(posedge mclk_i) disable iff (!rst_n) // R09
        $fell(soft_max_q) && last_kind_o == RK_MAX |=> boot_start_o)
        else $error("no boot after max reset");
    a_wdt_block: assert property (@(posedge mclk_i) disable iff (!rst_n) // R12
        watchdog_expiry_i && emu_block_wdt_i && !emu_max_req_i && !emu_sys_req_i && core_rst_n_o
            |=> core_rst_n_o || !global_reset_n_i)
        else $error("blocked watchdog reset ran");
    a_sync_release: assert property (@(posedge mclk_i) disable iff (!rst_n) // R13
        $rose(core_req_n) ##1 core_req_n [*2] |-> core_rst_n_o && !$past(core_rst_n_o) && !$past(core_rst_n_o, 2))
        else $error("core release not two stage");
    c_por: cover property (@(posedge mclk_i) !global_reset_n_i && !test_port_reset_n_i);
    c_warm: cover property (@(posedge mclk_i) !global_reset_n_i && test_port_reset_n_i);
    c_max: cover property (@(posedge mclk_i) soft_go);
    c_sys: cover property (@(posedge mclk_i) soft_sys_q);
    c_mod: cover property (@(posedge mclk_i) sw_mod_rst_i);
endmodule : chip_reset_sequencer

// >>> rtl/rst_seq_pkg.sv
package rst_seq_pkg;
    // ============================================================
    // Reset kinds
    typedef enum logic [2:0] {
        RK_NONE = 3'b000,
        RK_POR = 3'b001,
        RK_WARM = 3'b010,
        RK_MAX = 3'b011,
        RK_SYS = 3'b100
    } rst_kind_t;

    // ============================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_BOOT = 2'b10
    } seq_state_t;

    // ============================================================
    // Widths and timing
    localparam int CFG_W = 6;
    localparam int MOD_W = 8;
    localparam int MOD_IDX_W = 3;
    localparam logic [CFG_W-1:0] CFG_RST_VAL = 6'h0d;
    localparam int CLK_MHZ = 40;
    localparam int SOFT_HOLD_NS = 200;
    localparam int SOFT_HOLD_CYC = (SOFT_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] SOFT_HOLD_CNT = 4'(SOFT_HOLD_CYC);
    localparam logic [3:0] BOOT_PULSE_CNT = 4'h1;
endpackage : rst_seq_pkg

// >>> rtl/rst_sync.sv
module rst_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    output logic rst_n_o
);
    logic meta_q;

    // ============================================================
    // Assert async, release after two edges
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= 1'b0;
            rst_n_o <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            rst_n_o <= meta_q;
        end
    end
endmodule : rst_sync

// >>> verif/board_emu_model.sv
module board_emu_model #(
    parameter int MIN_LOW_CYC = 16
) (
    input wire logic mclk_i,
    output logic global_reset_n_o,
    output logic test_port_reset_n_o,
    output logic watchdog_expiry_o,
    output logic emu_max_req_o,
    output logic emu_sys_req_o,
    output logic emu_block_wdt_o,
    output logic [rst_seq_pkg::CFG_W-1:0] cfg_pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import rst_seq_pkg::*;
    // ====
    // Pin reset source
    initial begin
        global_reset_n_o = 1'b0;
        test_port_reset_n_o = 1'b0;
        {watchdog_expiry_o, emu_max_req_o, emu_sys_req_o, emu_block_wdt_o} = 4'h0;
        cfg_pins_o = CFG_RST_VAL;
    end
    task automatic assert_pins(input logic tp_n, input logic [CFG_W-1:0] cfg);
        test_port_reset_n_o <= tp_n;
        global_reset_n_o <= 1'b0;
        cfg_pins_o <= cfg;
    endtask : assert_pins
    task automatic hold_release();
        repeat (MIN_LOW_CYC) @(posedge mclk_i);
        global_reset_n_o <= 1'b1;
    endtask : hold_release
    // Shared pins turn to bus use after sampling
    task automatic float_cfg();
        cfg_pins_o <= ~cfg_pins_o;
    endtask : float_cfg
    // ====
    // Watchdog and emulator requests
    task automatic pulse(input int which);
        watchdog_expiry_o <= (which == 0);
        emu_max_req_o <= (which == 1);
        emu_sys_req_o <= (which == 2);
        @(posedge mclk_i);
        {watchdog_expiry_o, emu_max_req_o, emu_sys_req_o} <= 3'h0;
    endtask : pulse
    task automatic set_block(input logic on);
        emu_block_wdt_o <= on;
    endtask : set_block
endmodule : board_emu_model

// >>> verif/chip_reset_sequencer_tb_top.sv
module chip_reset_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rst_seq_pkg::*;
    logic mclk_i = 1'b0, arst_n_i = 1'b0, sw_mod_rst_i = 1'b0;
    logic [MOD_IDX_W-1:0] sw_mod_sel_i = '0;
    logic g_n, tp_n, wdt, emax, esys, eblk, core_n, mem_n, emu_n, infra_n, boot;
    logic [CFG_W-1:0] cfg, cfg_lat;
    logic [MOD_W-1:0] mod_n;
    rst_kind_t kind, exp_kind;
    logic [CFG_W-1:0] exp_cfg;
    int fail_count = 0, checks = 0;
    always #12.5 mclk_i = ~mclk_i;
    board_emu_model p (.mclk_i(mclk_i), .global_reset_n_o(g_n), .test_port_reset_n_o(tp_n),
        .watchdog_expiry_o(wdt), .emu_max_req_o(emax), .emu_sys_req_o(esys),
        .emu_block_wdt_o(eblk), .cfg_pins_o(cfg));
    chip_reset_sequencer dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .global_reset_n_i(g_n),
        .test_port_reset_n_i(tp_n), .watchdog_expiry_i(wdt), .emu_max_req_i(emax),
        .emu_sys_req_i(esys), .emu_block_wdt_i(eblk), .cfg_pins_i(cfg), .sw_mod_rst_i(sw_mod_rst_i),
        .sw_mod_sel_i(sw_mod_sel_i), .core_rst_n_o(core_n), .mem_rst_n_o(mem_n), .emu_rst_n_o(emu_n),
        .infra_rst_n_o(infra_n), .mod_rst_n_o(mod_n), .cfg_latched_o(cfg_lat), .boot_start_o(boot),
        .last_kind_o(kind));
    // ====
    // Reference model and checking
    function automatic logic [3:0] dom_for(input rst_kind_t k);
        case (k)
            RK_POR: return 4'b0000;
            RK_WARM, RK_MAX: return 4'b0010;
            RK_SYS: return 4'b0111;
            default: return 4'b1111;
        endcase
    endfunction : dom_for
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_boot();
        int n;
        n = 0;
        while (boot !== 1'b1 && n < 60) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check(8'(boot), 8'h01);
    endtask : wait_boot
    task automatic settle_check();
        repeat (4) @(posedge mclk_i);
        #1;
        check(8'({core_n, mem_n, emu_n, infra_n}), 8'h0f);
        check(8'(kind), 8'(exp_kind));
        check(8'(cfg_lat), 8'(exp_cfg));
    endtask : settle_check
    task automatic summarize();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    // ====
    // Scenarios
    initial begin
        void'($urandom(32'hb16b));
        repeat (16) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk_i);
            exp_cfg = CFG_W'($urandom);
            exp_kind = (k == 1) ? RK_WARM : RK_POR;
            p.assert_pins(k == 1, exp_cfg);
            #1;
            check(8'({core_n, mem_n, emu_n, infra_n}), 8'(dom_for(exp_kind)));
            p.hold_release();
            wait_boot();
            settle_check();
            @(posedge mclk_i);
            p.float_cfg();
        end
        for (int w = 0; w < 4; w++) begin
            @(posedge mclk_i);
            p.set_block(w == 3);
            p.float_cfg();
            p.pulse(w % 3);
            if (w < 2)
                exp_cfg = cfg;
            repeat (2) @(posedge mclk_i);
            #1;
            check(8'({core_n, mem_n, emu_n, infra_n}),
                8'(dom_for(w < 2 ? RK_MAX : (w == 2 ? RK_SYS : RK_NONE))));
            if (w < 2) begin
                exp_kind = RK_MAX;
                wait_boot();
            end else begin
                if (w == 2)
                    exp_kind = RK_SYS;
                repeat (14) @(posedge mclk_i);
            end
            settle_check();
        end
        @(posedge mclk_i);
        p.set_block(1'b0);
        for (int m = 0; m < 3; m++) begin
            @(posedge mclk_i);
            sw_mod_sel_i <= MOD_IDX_W'($urandom);
            sw_mod_rst_i <= 1'b1;
            repeat (3) @(posedge mclk_i);
            #1;
            check(mod_n, ~(8'h01 << sw_mod_sel_i));
            check(8'({core_n, mem_n, emu_n, infra_n}), 8'h0f);
            @(posedge mclk_i);
            sw_mod_rst_i <= 1'b0;
            repeat (3) @(posedge mclk_i);
            #1;
            check(mod_n, 8'hff);
        end
        summarize();
    end
    initial begin
        repeat (4000) @(posedge mclk_i);
        fail_count++;
        summarize();
    end
endmodule : chip_reset_sequencer_tb_top
